//--- core/pcc_map.svh
/*
  Offsets, field positions and fixed values of the configuration header.
  Assumes inclusion by bare name from pcc_cfg_qual and pcc_config_header.
*/
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH
// ==========================================================
// Offsets (byte addresses of configuration doublewords)
`define PCC_OFF_IDENT 6'h00
`define PCC_OFF_CMDSTAT 6'h04
// ==========================================================
// Command field positions
`define PCC_B_IO 0
`define PCC_B_MEM 1
`define PCC_B_MST 2
`define PCC_B_SPC 3
`define PCC_B_MWI 4
`define PCC_B_VGA 5
`define PCC_B_PER 6
`define PCC_B_STP 7
`define PCC_B_SER 8
`define PCC_B_FBI 9
// ==========================================================
// Status field positions
`define PCC_B_HSC 21
`define PCC_B_FBT 23
`define PCC_B_DPR 24
`define PCC_B_TSL 25
`define PCC_B_TAS 27
`define PCC_B_TAR 28
`define PCC_B_MAR 29
`define PCC_B_SES 30
`define PCC_B_PED 31
// ==========================================================
// Fixed values
`define PCC_SEL_MEDIUM 2'h1
`define PCC_CMD_WMASK 16'h0146
`define PCC_ZERO32 32'h0000_0000
// Arbitrary neutral identity values
`define PCC_MAKER_CODE 16'h1234
`define PCC_PART_CODE 16'h5678
`endif

//--- core/pcc_pkg.sv
/*
  Types for the configuration header block.
  Assumes pcc_map.svh is on the include path.
*/
package pcc_pkg;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic target_abort_signalled;
    logic target_abort_received;
    logic master_abort_received;
    logic system_error_signalled;
    logic parity_error_detected;
    logic initiator_parity_error_detected;
  } pcc_evt_t;

  typedef struct packed {
    logic memory_space_enable;
    logic bus_master_enable;
    logic parity_response_enable;
    logic system_error_enable;
  } pcc_cmd_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] offset;
    logic [3:0] byte_en_n;
    logic [31:0] wdata;
  } pcc_req_t;
endpackage

//--- core/pcc_cfg_qual.sv
/*
  Qualifies a configuration access from the host bus interface.
  Assumes the request arrives synchronous with clk_i as one-cycle strobes.
*/
`timescale 1ns/100ps
`include "pcc_map.svh"
module pcc_cfg_qual
  import pcc_pkg::*;
(
  input wire logic cfg_cycle_i,
  input wire logic idsel_i,
  input wire pcc_req_t req_i,
  output pcc_req_t req_o
);
  // ==========================================================
  // Gate
  always_comb begin
    req_o = req_i;
    // Only an addressed configuration cycle is taken
    req_o.valid = req_i.valid & cfg_cycle_i & idsel_i;
  end
endmodule // pcc_cfg_qual

//--- core/pcc_status_flag.sv
/*
  One sticky status flag, write-one-to-clear.
  Assumes set and clear are one-cycle pulses on clk_i.
*/
`timescale 1ns/100ps
module pcc_status_flag (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic flag_ff;
  logic nxt_flag;
  // ==========================================================
  // Flag
  always_comb begin
    // Set beats clear; a write can never set
    nxt_flag = set_i | (flag_ff & ~clr_i);
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end
  assign flag_o = flag_ff;
endmodule // pcc_status_flag

//--- core/pcc_config_header.sv
/*
  Configuration header: identity and command/status registers.
  Assumes a host bus interface presents qualified configuration strobes
  and reports bus events as one-cycle pulses on clk_i.
*/
`timescale 1ns/100ps
`include "pcc_map.svh"
module pcc_config_header
  import pcc_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = `PCC_MAKER_CODE,
  parameter logic [15:0] PART_CODE = `PCC_PART_CODE
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cfg_cycle_i,
  input wire logic idsel_i,
  input wire pcc_req_t req_i,
  input wire pcc_evt_t evt_i,
  input wire logic data_parity_error_detected_i,
  input wire logic addr_parity_error_detected_i,
  input wire logic mem_cycle_i,
  input wire logic io_cycle_i,
  input wire logic master_want_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic mem_claim_o,
  output logic io_claim_o,
  output logic master_req_o,
  output logic parity_error_detected_drive_o,
  output logic system_error_signalled_drive_o,
  output pcc_cmd_t cmd_o
);
  // ==========================================================
  // State
  typedef struct packed {
    pcc_cmd_t cmd;
    logic [31:0] rdata;
    logic rvalid;
  } pcc_state_t;

  pcc_state_t st_ff;
  pcc_state_t nxt_st;
  pcc_req_t q_req;
  logic [5:0] flags;
  logic [5:0] flag_set;
  logic [5:0] flag_clr;
  logic wr_cs;
  logic system_error_signalled_evt;

  function automatic logic hit(input logic [5:0] off, input logic [5:0] a);
    hit = (off == a);
  endfunction

  // ==========================================================
  // Access qualification
  pcc_cfg_qual u_qual (
    .cfg_cycle_i(cfg_cycle_i),
    .idsel_i(idsel_i),
    .req_i(req_i),
    .req_o(q_req)
  );

  // All byte enables negated means no write; a read is still answered
  assign wr_cs = q_req.valid & q_req.write & ~&q_req.byte_en_n &
                 hit(q_req.offset, `PCC_OFF_CMDSTAT);

  // ==========================================================
  // Bus-side gating
  assign io_claim_o = 1'b0;
  assign mem_claim_o = mem_cycle_i & st_ff.cmd.memory_space_enable;
  assign master_req_o = master_want_i & st_ff.cmd.bus_master_enable;
  assign parity_error_detected_drive_o = data_parity_error_detected_i & st_ff.cmd.parity_response_enable;
  // Address parity needs both enables
  assign system_error_signalled_drive_o = addr_parity_error_detected_i & st_ff.cmd.system_error_enable &
                        st_ff.cmd.parity_response_enable;
  assign system_error_signalled_evt = system_error_signalled_drive_o | evt_i.system_error_signalled;

  // ==========================================================
  // Status flags, order matches bits 24 and 27..31
  assign flag_set = {evt_i.parity_error_detected | data_parity_error_detected_i |
                     addr_parity_error_detected_i,
                     system_error_signalled_evt,
                     evt_i.master_abort_received,
                     evt_i.target_abort_received,
                     evt_i.target_abort_signalled,
                     evt_i.initiator_parity_error_detected &
                     st_ff.cmd.parity_response_enable};
  assign flag_clr = {q_req.wdata[`PCC_B_PED:`PCC_B_TAS],
                     q_req.wdata[`PCC_B_DPR]} & {6{wr_cs}};

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_flag
      pcc_status_flag u_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(flag_set[g]),
        .clr_i(flag_clr[g]),
        .flag_o(flags[g])
      );
    end
  endgenerate

  // ==========================================================
  // Register logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    if (wr_cs) begin
      // Only writable command bits take the data
      nxt_st.cmd.memory_space_enable = q_req.wdata[`PCC_B_MEM];
      nxt_st.cmd.bus_master_enable = q_req.wdata[`PCC_B_MST];
      nxt_st.cmd.parity_response_enable = q_req.wdata[`PCC_B_PER];
      nxt_st.cmd.system_error_enable = q_req.wdata[`PCC_B_SER];
    end
    if (q_req.valid & ~q_req.write) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = `PCC_ZERO32;
      case (q_req.offset)
        `PCC_OFF_IDENT: begin
          nxt_st.rdata = {PART_CODE, MAKER_CODE};
        end
        `PCC_OFF_CMDSTAT: begin
          nxt_st.rdata[`PCC_B_MEM] = st_ff.cmd.memory_space_enable;
          nxt_st.rdata[`PCC_B_MST] = st_ff.cmd.bus_master_enable;
          nxt_st.rdata[`PCC_B_PER] = st_ff.cmd.parity_response_enable;
          nxt_st.rdata[`PCC_B_SER] = st_ff.cmd.system_error_enable;
          // Bits 0,3,4,5,7,9 stay zero
          nxt_st.rdata[`PCC_B_HSC] = 1'b1;
          nxt_st.rdata[`PCC_B_FBT] = 1'b1;
          nxt_st.rdata[`PCC_B_TSL+1:`PCC_B_TSL] = `PCC_SEL_MEDIUM;
          nxt_st.rdata[`PCC_B_DPR] = flags[0];
          nxt_st.rdata[`PCC_B_PED:`PCC_B_TAS] = flags[5:1];
        end
        default: begin
          nxt_st.rdata = `PCC_ZERO32;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign rvalid_o = st_ff.rvalid;
  assign cmd_o = st_ff.cmd;
endmodule // pcc_config_header

//--- verif/pcc_hdr_asserts.sv
/* Port checker for the configuration header.
   Bound into pcc_config_header; sees only its ports. */
`timescale 1ns/100ps
module pcc_hdr_asserts
  import pcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cfg_cycle_i,
  input wire logic idsel_i,
  input wire pcc_req_t req_i,
  input wire logic data_parity_error_detected_i,
  input wire logic addr_parity_error_detected_i,
  input wire logic mem_cycle_i,
  input wire logic master_want_i,
  input wire logic [31:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic mem_claim_o,
  input wire logic io_claim_o,
  input wire logic master_req_o,
  input wire logic parity_error_detected_drive_o,
  input wire logic system_error_signalled_drive_o,
  input wire pcc_cmd_t cmd_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic tk = req_i.valid & cfg_cycle_i & idsel_i;
  // ====
  // Gating and answers
  io_never_a: assert property (!io_claim_o)
    else $error("io claimed");
  mem_claim_a: assert property (
    mem_claim_o == (mem_cycle_i & cmd_o.memory_space_enable))
    else $error("mem claim wrong");
  master_req_a: assert property (
    master_req_o == (master_want_i & cmd_o.bus_master_enable))
    else $error("master req wrong");
  parity_error_detected_gate_a: assert property (
    parity_error_detected_drive_o == (data_parity_error_detected_i & cmd_o.parity_response_enable))
    else $error("parity_error_detected drive wrong");
  system_error_signalled_gate_a: assert property (
    system_error_signalled_drive_o == (addr_parity_error_detected_i & cmd_o.system_error_enable &
    cmd_o.parity_response_enable)) else $error("system_error_signalled drive wrong");
  read_ans_a: assert property (tk && !req_i.write |=> rvalid_o)
    else $error("read not answered");
  no_take_a: assert property (!tk |=> !rvalid_o)
    else $error("unselected answer");
  cmd_hold_a: assert property (
    !(tk && req_i.write && req_i.offset == 6'h04) |=> $stable(cmd_o))
    else $error("cmd changed");
  fixed_bits_a: assert property (
    rvalid_o && $past(req_i.offset) == 6'h04 |->
    {rdata_o[26:25], rdata_o[23:21], rdata_o[9:0] & 10'h2B9} == 15'h3400)
    else $error("fixed bits wrong");
  cover property (tk && req_i.write);
  cover property (system_error_signalled_drive_o);
  cover property (parity_error_detected_drive_o);
endmodule // pcc_hdr_asserts
bind pcc_config_header pcc_hdr_asserts chk (.*);

//--- verif/pcc_host_model.sv
/* Host bridge model issuing configuration cycles.
   Drives on falling clk_i; answer expected one cycle after the take. */
`timescale 1ns/100ps
module pcc_host_model
  import pcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i,
  output logic cfg_cycle_o,
  output logic idsel_o,
  output pcc_req_t req_o
);
  initial begin
    cfg_cycle_o = 1'h0;
    idsel_o = 1'h0;
    req_o = '0;
  end
  // ====
  // Whole doubleword, all lanes enabled
  task automatic cfg(input logic w, input logic [5:0] off,
    input logic [31:0] d, input logic sel, output logic [31:0] q);
    @(negedge clk_i);
    cfg_cycle_o = 1'h1;
    idsel_o = sel;
    req_o = {1'h1, w, off, 4'h0, d};
    @(negedge clk_i);
    q = (rvalid_i === 1'h1) ? rdata_i : 'x;
    cfg_cycle_o = 1'h0;
    idsel_o = 1'h0;
    req_o.valid = 1'h0;
    // Released data toggles so stale values never pass
    req_o.wdata = ~d;
  endtask
endmodule // pcc_host_model

//--- verif/test_pcc_config_header.sv
/* Self-checking bench for the configuration header.
   Needs pcc_host_model and the pcc_pkg types. */
`timescale 1ns/100ps
module test_pcc_config_header
  import pcc_pkg::*;
;
  typedef struct packed {logic w; logic [5:0] off; logic [31:0] d;} pcc_row_t;
  // Arbitrary identity values
  localparam logic [15:0] MK = 16'hA5C3;
  localparam logic [15:0] PT = 16'h3C5A;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cfg_cycle_i, idsel_i, rvalid_o, mem_claim_o, io_claim_o;
  logic master_req_o, parity_error_detected_drive_o, system_error_signalled_drive_o;
  logic data_parity_error_detected_i = 1'h0;
  logic addr_parity_error_detected_i = 1'h0;
  logic mem_cycle_i = 1'h1;
  logic io_cycle_i = 1'h1;
  logic master_want_i = 1'h1;
  logic [31:0] rdata_o, q;
  pcc_req_t req_i;
  pcc_evt_t evt_i = '0;
  pcc_cmd_t cmd_o;
  int n_fail = 0;
  int checks = 0;
  // Reads carry the expected value in d
  pcc_row_t rows [9] = '{{1'h0, 6'h04, 32'h02A0_0000},
    {1'h0, 6'h00, 32'h3C5A_A5C3}, {1'h1, 6'h00, 32'hFFFF_FFFF},
    {1'h0, 6'h00, 32'h3C5A_A5C3}, {1'h1, 6'h04, 32'h0000_FFFF},
    {1'h0, 6'h04, 32'h02A0_0146}, {1'h0, 6'h08, 32'h0000_0000},
    {1'h1, 6'h04, 32'h0000_0000}, {1'h0, 6'h04, 32'h02A0_0000}};
  always #4 clk_i = ~clk_i;
  pcc_config_header #(.MAKER_CODE(MK), .PART_CODE(PT)) uut (.*);
  pcc_host_model host (.clk_i(clk_i), .rdata_i(rdata_o),
    .rvalid_i(rvalid_o), .cfg_cycle_o(cfg_cycle_i), .idsel_o(idsel_i),
    .req_o(req_i));
  // ====
  // Helpers
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task give_verdict;
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task rd(input logic [5:0] off, input logic [31:0] e);
    host.cfg(1'h0, off, 32'h0000_0000, 1'h1, q);
    chk("rdata", e, q);
  endtask
  task wr(input logic [5:0] off, input logic [31:0] d, input logic s);
    host.cfg(1'h1, off, d, s, q);
  endtask
  task pulse(input pcc_evt_t e, input logic dp, input logic ap,
    input logic [8:0] ep);
    @(negedge clk_i);
    evt_i = e;
    data_parity_error_detected_i = dp;
    addr_parity_error_detected_i = ap;
    // Gating outputs are combinational; look well clear of any edge
    #1;
    chk("pins", {23'h0, ep},
      {23'h0, parity_error_detected_drive_o, system_error_signalled_drive_o, mem_claim_o, master_req_o,
      io_claim_o, cmd_o});
    @(negedge clk_i);
    evt_i = '0;
    data_parity_error_detected_i = 1'h0;
    addr_parity_error_detected_i = 1'h0;
  endtask
  // ====
  // Sequence
  initial begin
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'h0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].off, rows[i].d, 1'h1);
      else rd(rows[i].off, rows[i].d);
    end
    wr(6'h04, 32'h0000_FFFF, 1'h0);
    rd(6'h04, 32'h02A0_0000);
    pulse(6'h3F, 1'h1, 1'h1, 9'h000);
    rd(6'h04, 32'hFAA0_0000);
    wr(6'h04, 32'h0800_0000, 1'h1);
    rd(6'h04, 32'hF2A0_0000);
    fork
      wr(6'h04, 32'hF000_0000, 1'h1);
      pulse(6'h10, 1'h0, 1'h0, 9'h000);
    join
    rd(6'h04, 32'h12A0_0000);
    wr(6'h04, 32'h0000_0146, 1'h1);
    pulse(6'h01, 1'h1, 1'h1, 9'h1EF);
    rd(6'h04, 32'hD3A0_0146);
    @(negedge clk_i);
    rst_i = 1'h1;
    @(negedge clk_i);
    rst_i = 1'h0;
    rd(6'h04, 32'h02A0_0000);
    give_verdict;
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    give_verdict;
  end
endmodule // test_pcc_config_header
